// [brake_interlock.sv]
// Holding-brake interlock sequencer with AXI4-Lite settings
`timescale 1ns/1ps
module brake_interlock #(
    parameter int TICK_CYCLES = brake_pkg::TICK_CYCLES, // Clocks per step
    parameter logic [12:0] MOTOR_MAX_RPM = 13'h0bb8, // Motor top speed
    parameter logic [12:0] STOP_RPM = 13'h0014 // Below this: stopped
) (
    input wire logic aclk, // System clock, 200 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic servo_on_in, // Servo-on pin, high = on
    input wire logic alarm_in, // Drive alarm pin, high = alarm
    input wire logic [12:0] motor_speed, // Measured speed, r/min
    input wire logic [5:0] other_out_sig, // Other signals per terminal
    output logic brake_release_out, // Low releases, high engages
    output logic motor_energize_out, // High keeps motor excited
    output logic general_output_one, // Terminal 1
    output logic general_output_two, // Terminal 2
    output logic general_output_three, // Terminal 3
    output logic general_output_four, // Terminal 4
    output logic general_output_five, // Terminal 5
    output logic general_output_six // Terminal 6
);
    import brake_pkg::*;

    typedef struct packed {
        logic on_s1;
        logic on_s2;
        logic alm_s1;
        logic alm_s2;
        seq_t st;
        logic [8:0] steps;
        logic brake;
        logic energize;
        logic [5:0] term;
        logic [2:0] assign_sel;
        logic [8:0] stop_dly;
        logic [12:0] spd_lvl;
        logic [6:0] wait_steps;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic tick;
    logic tick_restart;
    logic stopped;
    logic [12:0] eff_lvl;
    logic [8:0] steps_inc;
    logic [5:0] bk_route;

    // Fresh step timebase on every state change
    assign tick_restart = (s_nxt.st != s_r.st);

    step_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(tick_restart),
        .tick(tick)
    );

    // Speed comparisons; the clamp keeps a high level reachable
    assign stopped = (motor_speed < STOP_RPM);
    assign eff_lvl = (s_r.spd_lvl > MOTOR_MAX_RPM) ?
        MOTOR_MAX_RPM : s_r.spd_lvl;
    assign steps_inc = s_r.steps + 9'h001;

    // Brake routing per terminal, decoded from the assignment field
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_route
            assign bk_route[gi] = (s_r.assign_sel ==
                3'(gi + 1));
        end
    endgenerate

    // Merge the byte lanes of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Read data for a register offset; unmapped reads return zero
    function automatic logic [31:0] rd_mux(input state_t s,
                                           input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            ADDR_ASSIGN: v[ASSIGN_W-1:0] = s.assign_sel;
            ADDR_STOP_DLY: v[STOP_DLY_W-1:0] = s.stop_dly;
            ADDR_SPD_LVL: v[SPD_W-1:0] = s.spd_lvl;
            ADDR_WAIT: v[WAIT_W-1:0] = s.wait_steps;
            ADDR_STATUS: begin
                v[STAT_SERVO] = s.on_s2;
                v[STAT_ALARM] = s.alm_s2;
                v[STAT_BRAKE] = s.brake;
                v[STAT_ENERGY] = s.energize;
                v[STAT_STATE +: 2] = s.st;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic [31:0] m;
        logic mapped;
        m = 32'h0000_0000;
        mapped = 1'b0;
        s_nxt = s_r;

        // Pin synchronisers; only the second stage is read below
        s_nxt.on_s1 = servo_on_in;
        s_nxt.on_s2 = s_r.on_s1;
        s_nxt.alm_s1 = alarm_in;
        s_nxt.alm_s2 = s_r.alm_s1;

        // Write address and data may arrive in either order
        if (s_r.awready && s_axi_awvalid) begin
            s_nxt.awaddr = s_axi_awaddr;
            s_nxt.aw_have = 1'b1;
        end
        if (s_r.wready && s_axi_wvalid) begin
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
            s_nxt.w_have = 1'b1;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Commit a write once both halves are held
        if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            mapped = 1'b1;
            unique case (s_r.awaddr)
                ADDR_ASSIGN: begin
                    m = merge(32'(s_r.assign_sel), s_r.wdata, s_r.wstrb);
                    // Codes above six read back but route nowhere
                    s_nxt.assign_sel = m[ASSIGN_W-1:0];
                end
                ADDR_STOP_DLY: begin
                    m = merge(32'(s_r.stop_dly), s_r.wdata, s_r.wstrb);
                    s_nxt.stop_dly = (m > 32'(MAX_STOP_DLY)) ?
                        MAX_STOP_DLY : m[STOP_DLY_W-1:0];
                end
                ADDR_SPD_LVL: begin
                    m = merge(32'(s_r.spd_lvl), s_r.wdata, s_r.wstrb);
                    s_nxt.spd_lvl = (m > 32'(MAX_SPD_LVL)) ?
                        MAX_SPD_LVL : m[SPD_W-1:0];
                end
                ADDR_WAIT: begin
                    m = merge(32'(s_r.wait_steps), s_r.wdata, s_r.wstrb);
                    if (m > 32'(MAX_WAIT)) begin
                        s_nxt.wait_steps = MAX_WAIT;
                    end else if (m < 32'(MIN_WAIT)) begin
                        s_nxt.wait_steps = MIN_WAIT;
                    end else begin
                        s_nxt.wait_steps = m[WAIT_W-1:0];
                    end
                end
                ADDR_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
            s_nxt.bresp = mapped ? RESP_OKAY : RESP_SLVERR;
        end
        s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

        // Read channel: answer in the cycle after the address is taken
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_r.arready && s_axi_arvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_mux(s_r, s_axi_araddr);
            s_nxt.rresp = (s_axi_araddr <= ADDR_STATUS &&
                           s_axi_araddr[1:0] == 2'h0) ?
                RESP_OKAY : RESP_SLVERR;
        end
        s_nxt.arready = !s_nxt.rvalid; // One read at a time
        // Brake sequencer
        unique case (s_r.st)
            ST_OFF: begin
                if (s_r.on_s2 && !s_r.alm_s2) begin
                    s_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (s_r.alm_s2) begin
                    // Excitation goes now; a spinning motor coasts
                    s_nxt.st = stopped ? ST_OFF : ST_ROT_WAIT;
                end else if (!s_r.on_s2) begin
                    if (!stopped) begin
                        s_nxt.st = ST_ROT_WAIT;
                    end else if (s_r.stop_dly == 9'h000) begin
                        s_nxt.st = ST_OFF;
                    end else begin
                        s_nxt.st = ST_STOP_DLY;
                    end
                end
            end
            ST_STOP_DLY: begin
                if (s_r.alm_s2) begin
                    s_nxt.st = ST_OFF;
                end else if (s_r.on_s2) begin
                    s_nxt.st = ST_RUN;
                end else if (tick && steps_inc >= s_r.stop_dly) begin
                    s_nxt.st = ST_OFF;
                end else if (tick) begin
                    s_nxt.steps = steps_inc;
                end
            end
            ST_ROT_WAIT: begin
                // Whichever of speed and timeout comes first wins
                if (motor_speed < eff_lvl) begin
                    s_nxt.st = ST_OFF;
                end else if (tick &&
                             steps_inc >= 9'(s_r.wait_steps)) begin
                    s_nxt.st = ST_OFF;
                end else if (tick) begin
                    s_nxt.steps = steps_inc;
                end
            end
        endcase
        if (s_nxt.st != s_r.st) begin
            s_nxt.steps = 9'h000;
        end

        // Outputs follow the next state so they leave a flip-flop
        s_nxt.brake = (s_nxt.st == ST_OFF) ||
                      (s_nxt.st == ST_STOP_DLY);
        s_nxt.energize = (s_nxt.st == ST_RUN) ||
                         (s_nxt.st == ST_STOP_DLY);
        s_nxt.term = other_out_sig | (bk_route & {6{s_nxt.brake}});
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.st <= ST_OFF;
            s_r.brake <= 1'b1;
            s_r.assign_sel <= RST_ASSIGN;
            s_r.stop_dly <= RST_STOP_DLY;
            s_r.spd_lvl <= RST_SPD_LVL;
            s_r.wait_steps <= RST_WAIT;
            s_r.bresp <= RESP_OKAY;
            s_r.rresp <= RESP_OKAY;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Port drive straight from the state register
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign brake_release_out = s_r.brake;
    assign motor_energize_out = s_r.energize;
    assign general_output_one = s_r.term[0];
    assign general_output_two = s_r.term[1];
    assign general_output_three = s_r.term[2];
    assign general_output_four = s_r.term[3];
    assign general_output_five = s_r.term[4];
    assign general_output_six = s_r.term[5];

    // Cycles spent waiting on a rotating motor, for the timeout bound
    int rot_cycles;
    always_ff @(posedge aclk) begin
        if (!aresetn || s_r.st != ST_ROT_WAIT) begin
            rot_cycles <= 0;
        end else begin
            rot_cycles <= rot_cycles + 1;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Running means released brake
    a_run_released: assert property (
        s_r.st == ST_RUN |-> !brake_release_out
    ) else $error("brake engaged while running");

    // Unused assignment leaves terminal one to its other signal
    a_term_unused: assert property (
        $past(s_r.assign_sel) == 3'h0 |->
        general_output_one == $past(other_out_sig[0])
    ) else $error("brake leaked onto an unassigned terminal");

    // Terminal six carries the brake when routed there
    a_term_or_brake: assert property (
        $past(s_r.assign_sel) == 3'h6 && brake_release_out |->
        general_output_six && general_output_five ==
        $past(other_out_sig[4])
    ) else $error("terminal OR of brake wrong");

    // Zero delay: brake and excitation change together
    a_zero_delay: assert property (
        s_r.st == ST_RUN && !s_r.on_s2 && !s_r.alm_s2 && stopped &&
        s_r.stop_dly == 9'h000 |=>
        brake_release_out && !motor_energize_out
    ) else $error("zero-delay servo off sequence wrong");

    // During the stop delay the motor stays excited under the brake
    a_delay_hold: assert property (
        s_r.st == ST_RUN && !s_r.on_s2 && !s_r.alm_s2 && stopped &&
        s_r.stop_dly != 9'h000 |=>
        brake_release_out && motor_energize_out
    ) else $error("stop delay not holding excitation");

    // Rotating servo off goes to the speed wait
    a_rot_path: assert property (
        s_r.st == ST_RUN && !s_r.on_s2 && !s_r.alm_s2 && !stopped |=>
        s_r.st == ST_ROT_WAIT && !motor_energize_out
    ) else $error("rotating servo off used the stop delay");

    // Alarm removes excitation on the next edge
    a_alarm_cut: assert property (
        s_r.alm_s2 |=> !motor_energize_out
    ) else $error("excitation kept during alarm");

    // While coasting the brake stays released
    a_coast_free: assert property (
        s_r.st == ST_ROT_WAIT |-> !brake_release_out && !motor_energize_out
    ) else $error("brake applied while motor coasting");

    // Speed below the level engages the brake
    a_speed_brake: assert property (
        s_r.st == ST_ROT_WAIT && motor_speed < eff_lvl |=>
        brake_release_out
    ) else $error("brake late after speed fell");

    // Wait never exceeds its setting in steps
    a_wait_bound: assert property (
        s_r.st == ST_ROT_WAIT |->
        rot_cycles <= int'(s_r.wait_steps) * TICK_CYCLES + 1
    ) else $error("brake wait timeout overran");

    // A level above top speed acts as top speed
    a_level_clamp: assert property (
        s_r.st == ST_ROT_WAIT && s_r.spd_lvl > MOTOR_MAX_RPM &&
        motor_speed < MOTOR_MAX_RPM |=> brake_release_out
    ) else $error("speed level not clamped to motor maximum");

    // Delay ends on the step that reaches the setting
    a_delay_end: assert property (
        s_r.st == ST_STOP_DLY && !s_r.alm_s2 && !s_r.on_s2 && tick &&
        steps_inc >= s_r.stop_dly |=> s_r.st == ST_OFF
    ) else $error("stop delay did not end on its step");

    c_stop_delay: cover property (
        s_r.st == ST_STOP_DLY ##1 s_r.st == ST_OFF
    );
    c_rot_speed: cover property (
        s_r.st == ST_ROT_WAIT && motor_speed < eff_lvl
    );
    c_alarm_run: cover property (
        s_r.st == ST_RUN && s_r.alm_s2
    );

endmodule

// [brake_pkg.sv]
// Shared constants and types for the holding-brake interlock
package brake_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_ASSIGN = 8'h00;
    localparam logic [7:0] ADDR_STOP_DLY = 8'h04;
    localparam logic [7:0] ADDR_SPD_LVL = 8'h08;
    localparam logic [7:0] ADDR_WAIT = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Field widths, all fields sit at bit 0
    localparam int ASSIGN_W = 3;
    localparam int STOP_DLY_W = 9;
    localparam int SPD_W = 13;
    localparam int WAIT_W = 7;

    // Reset values and legal ranges
    localparam logic [2:0] RST_ASSIGN = 3'h0;
    localparam logic [8:0] RST_STOP_DLY = 9'h000;
    localparam logic [8:0] MAX_STOP_DLY = 9'h1f4; // 500 steps
    localparam logic [12:0] RST_SPD_LVL = 13'h0064; // 100 r/min
    localparam logic [12:0] MAX_SPD_LVL = 13'h1770; // 6000 r/min
    localparam logic [6:0] RST_WAIT = 7'h32; // 50 steps
    localparam logic [6:0] MIN_WAIT = 7'h0a; // 10 steps
    localparam logic [6:0] MAX_WAIT = 7'h64; // 100 steps
    localparam logic [2:0] TERM_COUNT = 3'h6;

    // Status register bit positions
    localparam int STAT_SERVO = 0;
    localparam int STAT_ALARM = 1;
    localparam int STAT_BRAKE = 2;
    localparam int STAT_ENERGY = 3;
    localparam int STAT_STATE = 4;

    // Timebase: one step is 10 ms at a 5 ns clock
    localparam int TICK_MS = 10;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_STOP_DLY,
        ST_ROT_WAIT
    } seq_t;

endpackage

// [step_tick.sv]
// Restartable 10 ms step tick generator
`timescale 1ns/1ps
module step_tick #(
    parameter int CYCLES = brake_pkg::TICK_CYCLES // Clocks per step
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic restart, // Restart the step from zero
    output logic tick // One-cycle pulse per step
);
    import brake_pkg::*;

    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic tick;
    } tick_t;

    tick_t t_r;
    tick_t t_nxt;

    // Restart aligns the first tick to a full step after state entry
    always_comb begin
        t_nxt = t_r;
        t_nxt.tick = 1'b0;
        if (restart) begin
            t_nxt.count = '0;
        end else if (t_r.count == LAST) begin
            t_nxt.count = '0;
            t_nxt.tick = 1'b1;
        end else begin
            t_nxt.count = t_r.count + CW'(1);
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign tick = t_r.tick;

endmodule

// [brake_relay_model.sv]
// Behavioural brake relay and spring-applied holding brake at a terminal
`timescale 1ns/1ps
module brake_relay_model #(
    parameter int DELAY = 1 // Edges of relay and armature lag
) (
    input wire logic aclk, // System clock
    input wire logic coil_in, // Terminal level, high engages the brake
    output logic brake_held // High while the brake holds the shaft
);
    int cnt = 0;

    // Brake follows the terminal after a mechanical lag; a slow relay
    // is modelled by a larger lag; a change undone within the lag is skipped
    // Shaft speed is not modelled; a wait timeout can engage it on a turning shaft
    always @(posedge aclk) begin
        if (coil_in === brake_held) begin
            cnt <= 0;
        end else if (cnt >= DELAY) begin
            brake_held <= coil_in;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // Unpowered spring brake starts out holding
    initial brake_held = 1'b1;
endmodule

// [tb.sv]
// Self-checking bench for the holding-brake interlock
`timescale 1ns/1ps
module tb;
    import brake_pkg::*;
    localparam int TK = 4; // Short step keeps the run brief
    logic aclk = 1'b0, aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic servo_on_in = 1'b0, alarm_in = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [12:0] motor_speed = 13'h0, sp;
    logic [5:0] other_out_sig = 6'h00, term;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, brake_release_out, motor_energize_out, held;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int fail_count = 0, cmp_count = 0, cyc = 0, asg = 0;
    int rq[$] = '{0, 0, 100, 50};
    int ca[$] = '{4, 8, 12, 12};
    int cw[$] = '{600, 7000, 3, 200};
    int ce[$] = '{500, 6000, 10, 100};

    brake_interlock #(.TICK_CYCLES(TK)) brake_interlock_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .servo_on_in, .alarm_in,
        .motor_speed, .other_out_sig, .brake_release_out,
        .motor_energize_out, .general_output_one(term[0]),
        .general_output_two(term[1]), .general_output_three(term[2]),
        .general_output_four(term[3]), .general_output_five(term[4]),
        .general_output_six(term[5]));
    brake_relay_model #(.DELAY(1)) brake_relay_model_i (
        .aclk, .coil_in(term[1]), .brake_held(held));

    // 200 MHz clock
    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // Cycle ceiling cuts a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize;
        end
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask

    // Write; each of address and data is released once it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Pins change together; other signals stay off terminal two
    task automatic pins(input logic s, a, input logic [12:0] v, input int n);
        servo_on_in <= s;
        alarm_in <= a;
        motor_speed <= v;
        other_out_sig <= 6'($urandom()) & 6'h3d;
        repeat (n) @(posedge aclk);
    endtask

    // Terminal model: other signals ORed with the routed brake
    function automatic logic [5:0] exp_term(int a, int o, int b);
        logic [5:0] m;
        m = (a >= 1 && a <= 6 && b != 0) ? 6'(1 << (a - 1)) : 6'h00;
        return 6'(o) | m;
    endfunction

    task automatic outs(input logic b, e);
        chk("brake", b, brake_release_out);
        chk("energize", e, motor_energize_out);
        chk("terminals", exp_term(asg, other_out_sig, b), term);
    endtask

    initial begin
        void'($urandom(32'he31f256f));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rq[i]) begin
            rd_reg(8'(4 * i));
            chk("reset value", rq[i], rd);
        end
        rd_reg(8'h14);
        chk("unmapped rresp", RESP_SLVERR, rs);
        wr(8'h14, 32'h1);
        chk("unmapped bresp", RESP_SLVERR, rs);
        // Settings outside their range are held at the limits
        foreach (ca[i]) begin
            wr(8'(ca[i]), cw[i]);
            rd_reg(8'(ca[i]));
            chk("clamped", ce[i], rd);
        end
        // Every routing code, brake engaged while off
        for (asg = 0; asg < 8; asg++) begin
            wr(8'h00, asg);
            pins(1'b0, 1'b0, 13'h0, 5);
            chk("route", exp_term(asg, other_out_sig, 1), term);
        end
        asg = 2;
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h0);
        pins(1'b1, 1'b0, 13'h0, 8);
        outs(1'b0, 1'b1);
        rd_reg(8'h10);
        chk("status", 32'h19, rd);
        pins(1'b0, 1'b0, 13'h0, 5);
        outs(1'b1, 1'b0);
        pins(1'b0, 1'b0, 13'h0, 4);
        chk("relay", 1'b1, held);
        // Stopped: brake first, excitation dropped after the delay
        wr(8'h04, 32'h5);
        pins(1'b1, 1'b0, 13'h0, 8);
        pins(1'b0, 1'b0, 13'h0, 8);
        outs(1'b1, 1'b1);
        pins(1'b0, 1'b0, 13'h0, 20);
        outs(1'b1, 1'b0);
        // Alarm ends a long delay at once
        wr(8'h04, 32'd500);
        pins(1'b1, 1'b0, 13'h0, 8);
        pins(1'b0, 1'b0, 13'h0, 8);
        pins(1'b0, 1'b1, 13'h0, 8);
        outs(1'b1, 1'b0);
        // Rotating: the long delay must not apply, the speed level does
        wr(8'h08, 32'd100);
        sp = 13'(100 + $urandom_range(2000));
        pins(1'b1, 1'b0, sp, 8);
        pins(1'b0, 1'b0, sp, 8);
        outs(1'b0, 1'b0);
        pins(1'b0, 1'b0, 13'd99, 8);
        outs(1'b1, 1'b0);
        // Level above motor top speed acts as the top speed
        wr(8'h08, 32'd6000);
        pins(1'b1, 1'b0, 13'd3100, 8);
        pins(1'b0, 1'b0, 13'd3100, 8);
        outs(1'b0, 1'b0);
        pins(1'b0, 1'b0, 13'd2990, 8);
        outs(1'b1, 1'b0);
        // Level zero: only the wait ends it
        wr(8'h08, 32'h0);
        wr(8'h0c, 32'd10);
        pins(1'b1, 1'b0, sp, 8);
        pins(1'b0, 1'b0, sp, 30);
        outs(1'b0, 1'b0);
        pins(1'b0, 1'b0, sp, 20);
        outs(1'b1, 1'b0);
        // Alarm while rotating: coast, brake once slow
        wr(8'h08, 32'd100);
        wr(8'h0c, 32'd100);
        pins(1'b1, 1'b0, sp, 8);
        pins(1'b1, 1'b1, sp, 8);
        outs(1'b0, 1'b0);
        pins(1'b1, 1'b1, 13'h0, 8);
        outs(1'b1, 1'b0);
        summarize;
    end
endmodule
